// >>> rtl/aux_cfg_pkg.sv
// constants, types and field layout for the auxiliary control and configuration block
// Summary of operation
// - keypad irq flag bit 7 sets on a falling edge at an enabled keypad pin, holds until software or a chip reset clears.
// - brownout disable bit 6 switches brownout detection off.
// - brownout irq select bit 5 turns brownout reset into an interrupt.
// - low power memory bit 4 set by software, cleared only by power-on/brownout reset.
// - writing one at bit 3 resets the whole processor, restart at 0000.
// - bit 2 always reads zero and ignores writes.
// - incrementing the register toggles pointer select without touching other bits.
// - two 16-bit data pointers, bit 0 selects which one is accessible.
// - all pointer operations and byte accesses go to the selected pointer.
// - register is not bit addressable and resets to 00H.
// - signature bytes readable by code-space reads at FC30h, FC31h, FC60h.
// - customer data area readable by code-space reads FCE0h..FCFFh.
// - configuration fixed from power-up; byte one readable at FD00H.
// - config bit 7 zero disables watchdog reset, timer interrupt still allowed.
// - config bit 6 zero disables reset pin function, pin becomes input.
// - config bit 5 sets port reset level, one high, zero low.
// - config bit 4 selects brownout threshold, one 2.5 V, zero 3.8 V.
// - config bit 3 zero divides CPU clock by two for core and peripherals.
// - oscillator field decodes 111 ext, 011 rc, 010 low, 001 mid, 000 high.
// - unprogrammed configuration byte one reads FFH.
package aux_cfg_pkg;
	// ----------------------------------------
	// register addresses and reset values
	// ----------------------------------------
	localparam logic [7:0] AUX_CTRL_ADDR = 8'hA2;
	localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
	localparam logic [15:0] CFG_ONE_ADDR = 16'hFD00;
	localparam logic [7:0] CFG_UNPROGRAMMED = 8'hFF;
	localparam logic [15:0] SIG_ADDR_0 = 16'hFC30;
	localparam logic [15:0] SIG_ADDR_1 = 16'hFC31;
	localparam logic [15:0] SIG_ADDR_2 = 16'hFC60;
	localparam logic [15:0] CUST_BASE = 16'hFCE0;
	localparam logic [15:0] CUST_LAST = 16'hFCFF;
	localparam int CUST_DEPTH = 32;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	// ----------------------------------------
	// auxiliary control field positions
	// ----------------------------------------
	localparam int BIT_KEY_FLAG = 7;
	localparam int BIT_BO_OFF = 6;
	localparam int BIT_BO_IRQ = 5;
	localparam int BIT_LPM = 4;
	localparam int BIT_SOFT_RST = 3;
	localparam int BIT_ZERO = 2;
	localparam int BIT_RSVD = 1;
	localparam int BIT_PSEL = 0;
	// ----------------------------------------
	// configuration byte field positions and oscillator codes
	// ----------------------------------------
	localparam int CFG_WDOG = 7;
	localparam int CFG_PIN = 6;
	localparam int CFG_PORT = 5;
	localparam int CFG_BROWN = 4;
	localparam int CFG_RATE = 3;
	localparam logic [2:0] OSC_EXT = 3'h7;
	localparam logic [2:0] OSC_RC = 3'h3;
	localparam logic [2:0] OSC_LOW = 3'h2;
	localparam logic [2:0] OSC_MID = 3'h1;
	localparam logic [2:0] OSC_HIGH = 3'h0;
	localparam logic [3:0] CYC_CLKS_FAST = 4'h6;
	localparam logic [3:0] CYC_CLKS_SLOW = 4'hC;
	// arbitrary neutral signature values
	localparam logic [7:0] SIG_BYTE_0 = 8'h5A;
	localparam logic [7:0] SIG_BYTE_1 = 8'hA5;
	localparam logic [7:0] SIG_BYTE_2 = 8'h3C;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [4:0]
	{
		OSC_SEL_EXT = 5'h01,
		OSC_SEL_RC = 5'h02,
		OSC_SEL_LOW = 5'h04,
		OSC_SEL_MID = 5'h08,
		OSC_SEL_HIGH = 5'h10
	} osc_mode_e;
	typedef struct packed
	{
		logic watchdog_reset_enable;
		logic reset_pin_disable;
		logic port_reset_level;
		logic brownout_level_select;
		logic clock_rate_select;
		logic [2:0] oscillator_type;
	} cfg_one_s;
	typedef struct packed
	{
		logic inc;
		logic load;
		logic wr_high;
		logic wr_low;
		logic [15:0] value;
	} ptr_op_s;
endpackage

// >>> rtl/aux_control_and_config_bytes.sv
// auxiliary control register, dual data pointers and configuration byte decode
`timescale 1ns/1ns
`default_nettype none
module aux_control_and_config_bytes
	import aux_cfg_pkg::*;
#(
	parameter int KEYPAD_PINS = 8
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic por_event,
	input wire logic bor_event,
	input wire logic wdt_event,
	input wire logic ext_reset_pin,
	input wire logic [7:0] cfg_one_raw,
	input wire logic [KEYPAD_PINS-1:0] keypad_pins,
	input wire logic [KEYPAD_PINS-1:0] keypad_enable,
	input wire logic brownout_detect,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire ptr_op_s ptr_op,
	output logic [15:0] data_pointer,
	input wire logic code_space_read,
	input wire logic external_space_move,
	input wire logic [15:0] space_addr,
	input wire logic cust_wr,
	input wire logic [4:0] cust_widx,
	input wire logic [7:0] cust_wdata,
	output logic [7:0] space_rdata,
	output logic space_hit,
	output logic chip_reset,
	output logic restart_at_zero,
	output logic brownout_enable,
	output logic brownout_irq,
	output logic brownout_level_select,
	output logic low_power_memory_ctrl,
	output logic watchdog_reset_enable,
	output logic shared_reset_pin_is_input,
	output logic port_reset_level,
	output logic [3:0] machine_cycle_clks,
	output osc_mode_e osc_mode,
	output logic osc_reserved
);
	// ----------------------------------------
	// configuration latch and decode
	// ----------------------------------------
	cfg_one_s cfg;
	logic cfg_loaded;
	logic keypad_irq_flag, brownout_disable, brownout_irq_select, pointer_select;
	logic software_reset_trigger;
	logic [15:0] ptr0, ptr1;
	logic [7:0] cust_mem [CUST_DEPTH];
	logic [7:0] keypad_prev;
	// config captured after reset release, never changed by software
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			cfg <= cfg_one_s'(CFG_UNPROGRAMMED);
			cfg_loaded <= 1'b0;
		end
		else if (por_event)
		begin
			cfg <= cfg_one_s'(cfg_one_raw);
			cfg_loaded <= 1'b1;
		end
		else if (!cfg_loaded)
		begin
			cfg <= cfg_one_s'(cfg_one_raw);
			cfg_loaded <= 1'b1;
		end
	assign watchdog_reset_enable = cfg.watchdog_reset_enable;
	assign shared_reset_pin_is_input = ~cfg.reset_pin_disable;
	assign port_reset_level = cfg.port_reset_level;
	assign brownout_level_select = cfg.brownout_level_select;
	assign machine_cycle_clks = cfg.clock_rate_select ? CYC_CLKS_FAST : CYC_CLKS_SLOW;
	// oscillator type decode
	always_comb
	begin
		osc_reserved = 1'b0;
		osc_mode = OSC_SEL_EXT;
		unique case (cfg.oscillator_type)
			OSC_EXT: osc_mode = OSC_SEL_EXT;
			OSC_RC: osc_mode = OSC_SEL_RC;
			OSC_LOW: osc_mode = OSC_SEL_LOW;
			OSC_MID: osc_mode = OSC_SEL_MID;
			OSC_HIGH: osc_mode = OSC_SEL_HIGH;
			default: osc_reserved = 1'b1;
		endcase
	end
	// ----------------------------------------
	// reset sources
	// ----------------------------------------
	wire power_reset = por_event | (bor_event & ~brownout_disable & ~brownout_irq_select);
	wire pin_reset = ext_reset_pin & cfg.reset_pin_disable;
	wire wdt_reset = wdt_event & cfg.watchdog_reset_enable;
	wire next_chip_reset = power_reset | pin_reset | wdt_reset | software_reset_trigger;
	assign brownout_enable = ~brownout_disable;
	assign brownout_irq = brownout_detect & ~brownout_disable & brownout_irq_select;
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			chip_reset <= 1'b1;
		else
			chip_reset <= next_chip_reset;
	assign restart_at_zero = chip_reset;
	// ----------------------------------------
	// auxiliary control register
	// ----------------------------------------
	wire aux_wr = sfr_wr & (sfr_addr == AUX_CTRL_ADDR); // byte write only
	wire [KEYPAD_PINS-1:0] key_fall = keypad_prev[KEYPAD_PINS-1:0] & ~keypad_pins & keypad_enable;
	wire key_event = |key_fall;
	// flag set wins over a concurrent software clear
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			keypad_irq_flag <= 1'b0;
			brownout_disable <= 1'b0;
			brownout_irq_select <= 1'b0;
			pointer_select <= 1'b0;
			software_reset_trigger <= 1'b0;
			keypad_prev <= 8'hFF;
		end
		else if (chip_reset)
		begin
			keypad_irq_flag <= 1'b0;
			brownout_disable <= 1'b0;
			brownout_irq_select <= 1'b0;
			pointer_select <= 1'b0;
			software_reset_trigger <= 1'b0;
			keypad_prev <= {8{1'b1}};
		end
		else
		begin
			keypad_prev[KEYPAD_PINS-1:0] <= keypad_pins;
			keypad_irq_flag <= key_event | (aux_wr ? sfr_wdata[BIT_KEY_FLAG] : keypad_irq_flag);
			if (aux_wr)
			begin
				brownout_disable <= sfr_wdata[BIT_BO_OFF];
				brownout_irq_select <= sfr_wdata[BIT_BO_IRQ];
				pointer_select <= sfr_wdata[BIT_PSEL];
				software_reset_trigger <= sfr_wdata[BIT_SOFT_RST];
			end
		end
	// low power bit survives soft, pin and watchdog resets
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			low_power_memory_ctrl <= 1'b0;
		else if (power_reset)
			low_power_memory_ctrl <= 1'b0;
		else if (aux_wr & sfr_wdata[BIT_LPM])
			low_power_memory_ctrl <= 1'b1;
	// read view: bit 2 zero, reserved bit 1 zero
	wire [7:0] aux_view = {keypad_irq_flag, brownout_disable, brownout_irq_select,
		low_power_memory_ctrl, software_reset_trigger, 1'b0, 1'b0, pointer_select};
	// ----------------------------------------
	// dual data pointers
	// ----------------------------------------
	wire [15:0] sel_ptr = pointer_select ? ptr1 : ptr0;
	wire [15:0] next_ptr = ptr_op.load ? ptr_op.value
		: ptr_op.inc ? sel_ptr + PTR_STEP
		: ptr_op.wr_high ? {ptr_op.value[15:8], sel_ptr[7:0]}
		: ptr_op.wr_low ? {sel_ptr[15:8], ptr_op.value[7:0]}
		: sel_ptr;
	wire ptr_touch = ptr_op.load | ptr_op.inc | ptr_op.wr_high | ptr_op.wr_low;
	// only the selected pointer updates on a pointer operation; chip reset clears both
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			ptr0 <= PTR_RESET;
			ptr1 <= PTR_RESET;
		end
		else if (chip_reset)
		begin
			ptr0 <= PTR_RESET;
			ptr1 <= PTR_RESET;
		end
		else if (ptr_touch)
		begin
			if (pointer_select)
				ptr1 <= next_ptr;
			else
				ptr0 <= next_ptr;
		end
	assign data_pointer = sel_ptr;
	// ----------------------------------------
	// customer area storage and space reads
	// ----------------------------------------
	always_ff @(posedge core_clk)
		if (cust_wr)
			cust_mem[cust_widx] <= cust_wdata;
	wire in_cust = (space_addr >= CUST_BASE) && (space_addr <= CUST_LAST);
	wire [4:0] cust_ridx = space_addr[4:0];
	wire sig_hit = (space_addr == SIG_ADDR_0) | (space_addr == SIG_ADDR_1)
		| (space_addr == SIG_ADDR_2);
	wire [7:0] sig_byte = (space_addr == SIG_ADDR_0) ? SIG_BYTE_0
		: (space_addr == SIG_ADDR_1) ? SIG_BYTE_1 : SIG_BYTE_2;
	wire code_hit = code_space_read & (sig_hit | in_cust);
	wire xdata_hit = external_space_move & (space_addr == CFG_ONE_ADDR);
	wire [7:0] next_space = xdata_hit ? cfg
		: (code_space_read & sig_hit) ? sig_byte
		: (code_space_read & in_cust) ? cust_mem[cust_ridx] : 8'h00;
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			space_rdata <= 8'h00;
			space_hit <= 1'b0;
			sfr_rdata <= AUX_CTRL_RESET;
		end
		else
		begin
			space_rdata <= next_space;
			space_hit <= code_hit | xdata_hit;
			sfr_rdata <= (sfr_addr == AUX_CTRL_ADDR) ? aux_view : 8'h00;
		end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_key_flag_sets: assert property (@(posedge core_clk) disable iff (!nrst)
		(key_event && !chip_reset) |=> keypad_irq_flag) else $error("keypad flag missed");
	a_key_flag_holds: assert property (@(posedge core_clk) disable iff (!nrst)
		(keypad_irq_flag && !aux_wr && !chip_reset) |=> keypad_irq_flag)
		else $error("keypad flag dropped");
	a_brownout_off: assert property (@(posedge core_clk) disable iff (!nrst)
		brownout_disable |-> !brownout_enable && !brownout_irq) else $error("brownout on");
	a_bo_irq_noreset: assert property (@(posedge core_clk) disable iff (!nrst)
		(bor_event && brownout_irq_select && !por_event && !software_reset_trigger
		&& !pin_reset && !wdt_reset) |=> !chip_reset) else $error("brownout reset");
	a_lpm_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
		(low_power_memory_ctrl && !power_reset) |=> low_power_memory_ctrl)
		else $error("low power bit cleared");
	a_soft_rst_fires: assert property (@(posedge core_clk) disable iff (!nrst)
		(aux_wr && sfr_wdata[BIT_SOFT_RST] && !chip_reset) |=> ##1 chip_reset)
		else $error("soft reset missed");
	a_soft_rst_once: assert property (@(posedge core_clk) disable iff (!nrst)
		(chip_reset) |=> !software_reset_trigger) else $error("soft reset stuck");
	a_bit2_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		sfr_rdata[BIT_ZERO] == 1'b0) else $error("bit 2 not zero");
	a_ptr_hidden: assert property (@(posedge core_clk) disable iff (!nrst)
		(pointer_select && !chip_reset) |=> $stable(ptr0)) else $error("hidden pointer moved");
	a_cfg_fixed: assert property (@(posedge core_clk) disable iff (!nrst)
		(cfg_loaded && !por_event) |=> $stable(cfg)) else $error("config changed");
	// ----------------------------------------
	// reset source assertions
	// ----------------------------------------
	a_bor_resets: assert property (@(posedge core_clk) disable iff (!nrst)
		(bor_event && !brownout_disable && !brownout_irq_select) |=> chip_reset)
		else $error("brownout reset missed");
	a_bo_off_noreset: assert property (@(posedge core_clk) disable iff (!nrst)
		(bor_event && brownout_disable && !por_event && !wdt_event && !ext_reset_pin
		&& !software_reset_trigger) |=> !chip_reset) else $error("disabled brownout reset");
	a_wdt_resets: assert property (@(posedge core_clk) disable iff (!nrst)
		(wdt_event && watchdog_reset_enable) |=> chip_reset) else $error("watchdog reset missed");
	a_wdt_masked: assert property (@(posedge core_clk) disable iff (!nrst)
		(wdt_event && !watchdog_reset_enable && !por_event && !bor_event && !ext_reset_pin
		&& !software_reset_trigger) |=> !chip_reset) else $error("masked watchdog reset");
	a_pin_resets: assert property (@(posedge core_clk) disable iff (!nrst)
		(ext_reset_pin && cfg.reset_pin_disable) |=> chip_reset) else $error("pin reset missed");
	a_pin_masked: assert property (@(posedge core_clk) disable iff (!nrst)
		(ext_reset_pin && !cfg.reset_pin_disable && !por_event && !bor_event && !wdt_event
		&& !software_reset_trigger) |=> !chip_reset) else $error("pin is not input only");
	a_lpm_power_clr: assert property (@(posedge core_clk) disable iff (!nrst)
		power_reset |=> !low_power_memory_ctrl) else $error("low power bit kept");
	// re-initialisation after any chip reset
	a_aux_reinit: assert property (@(posedge core_clk) disable iff (!nrst)
		chip_reset |=> !keypad_irq_flag && !brownout_disable && !brownout_irq_select)
		else $error("aux register not cleared");
	a_ptr_reinit: assert property (@(posedge core_clk) disable iff (!nrst)
		chip_reset |=> (ptr0 == PTR_RESET) && (ptr1 == PTR_RESET) && !pointer_select)
		else $error("pointers not cleared");
	a_bit1_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		sfr_rdata[BIT_RSVD] == 1'b0) else $error("reserved bit not zero");
	// pointer operations land on the selected pointer
	a_ptr_load: assert property (@(posedge core_clk) disable iff (!nrst)
		(ptr_op.load && !chip_reset && !aux_wr) |=> data_pointer == $past(ptr_op.value))
		else $error("pointer load lost");
	a_ptr_inc: assert property (@(posedge core_clk) disable iff (!nrst)
		(ptr_op.inc && !ptr_op.load && !chip_reset && !aux_wr)
		|=> data_pointer == $past(data_pointer) + PTR_STEP) else $error("pointer step lost");
	// space reads and configuration decode
	a_sig_read: assert property (@(posedge core_clk) disable iff (!nrst)
		(code_space_read && space_addr == SIG_ADDR_0)
		|=> space_hit && (space_rdata == SIG_BYTE_0)) else $error("signature read wrong");
	a_cust_hit: assert property (@(posedge core_clk) disable iff (!nrst)
		(code_space_read && space_addr >= CUST_BASE && space_addr <= CUST_LAST) |=> space_hit)
		else $error("customer area missed");
	a_cfg_read: assert property (@(posedge core_clk) disable iff (!nrst)
		(external_space_move && space_addr == CFG_ONE_ADDR)
		|=> space_hit && (space_rdata == $past(cfg))) else $error("config read wrong");
	a_cfg_default: assert property (@(posedge core_clk) disable iff (!nrst)
		!cfg_loaded |-> cfg == CFG_UNPROGRAMMED) else $error("config not unprogrammed");
	a_slow_cycle: assert property (@(posedge core_clk) disable iff (!nrst)
		!cfg.clock_rate_select |-> machine_cycle_clks == CYC_CLKS_SLOW)
		else $error("clock divide missing");
	a_osc_onehot: assert property (@(posedge core_clk) disable iff (!nrst)
		$onehot(osc_mode)) else $error("oscillator mode not one-hot");
	// main scenarios
	c_soft_reset: cover property (@(posedge core_clk) disable iff (!nrst)
		aux_wr && sfr_wdata[BIT_SOFT_RST]);
	c_ptr_toggle: cover property (@(posedge core_clk) disable iff (!nrst)
		$changed(pointer_select) && ptr_op.inc);
	c_cfg_read: cover property (@(posedge core_clk) disable iff (!nrst) xdata_hit);
	c_keypad_set: cover property (@(posedge core_clk) disable iff (!nrst) key_event);
	c_bor_irq: cover property (@(posedge core_clk) disable iff (!nrst) brownout_irq);
endmodule
`default_nettype wire

// >>> bench/core_model.sv
// processor core model driving register writes, reads, pointer ops and space reads
`timescale 1ns/1ns
`default_nettype none
module core_model
	import aux_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] sfr_rdata,
	input wire logic [7:0] space_rdata,
	input wire logic space_hit,
	output logic sfr_wr,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	output var ptr_op_s ptr_op,
	output logic code_space_read,
	output logic external_space_move,
	output logic [15:0] space_addr
);
	// ----------------------------------------
	// idle bus and access tasks, all launched at a falling edge
	// ----------------------------------------
	initial
	begin
		{sfr_wr, sfr_addr, sfr_wdata, code_space_read, external_space_move, space_addr} = '0;
		ptr_op = '0;
	end
	// one-cycle write strobe, then a quiet cycle so back-to-back calls never collide
	task sfr_write(input logic [7:0] a, input logic [7:0] wd);
		sfr_addr = a;
		sfr_wdata = wd & 8'hFD; // reserved bit never written as one
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
		@(negedge core_clk);
	endtask
	// registered read data is settled one falling edge later
	task sfr_read(input logic [7:0] a, output logic [7:0] rd);
		sfr_addr = a;
		@(negedge core_clk);
		rd = sfr_rdata;
	endtask
	task space_read(input logic code, input logic [15:0] a, output logic [7:0] rd, output logic hit);
		space_addr = a;
		code_space_read = code;
		external_space_move = !code;
		@(negedge core_clk);
		rd = space_rdata;
		hit = space_hit;
		{code_space_read, external_space_move} = 2'h0;
		@(negedge core_clk);
	endtask
	task ptr_cmd(input logic [3:0] k, input logic [15:0] v);
		ptr_op = {k, v};
		@(negedge core_clk);
		ptr_op = '0;
		@(negedge core_clk);
	endtask
endmodule
`default_nettype wire

// >>> bench/tb_aux_control_and_config_bytes.sv
// self-checking bench for the auxiliary control and configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_aux_control_and_config_bytes
	import aux_cfg_pkg::*;
;
	logic core_clk, nrst, brownout_detect, cust_wr, sfr_wr, code_space_read, external_space_move;
	logic space_hit, h, chip_reset, restart_at_zero, brownout_enable, brownout_irq, osc_reserved;
	logic brownout_level_select, low_power_memory_ctrl, watchdog_reset_enable, port_reset_level;
	logic shared_reset_pin_is_input;
	logic [3:0] ev, machine_cycle_clks;
	logic [7:0] cfg_one_raw, keypad_pins, keypad_enable, cust_wdata, sfr_addr, sfr_wdata;
	logic [7:0] sfr_rdata, space_rdata, d, c;
	logic [4:0] cust_widx;
	logic [15:0] space_addr, data_pointer;
	osc_mode_e osc_mode;
	ptr_op_s ptr_op;
	int err_count = 0, n_tests = 0, n, i;
	logic [7:0] cfg_tab [6] = '{8'hFF, 8'h3B, 8'hD2, 8'h41, 8'h80, 8'h05};
	logic [15:0] sig_a [3] = '{SIG_ADDR_0, SIG_ADDR_1, SIG_ADDR_2};
	logic [7:0] sig_v [3] = '{SIG_BYTE_0, SIG_BYTE_1, SIG_BYTE_2};
	// ----------------------------------------
	// design, core model, clock and watchdog
	// ----------------------------------------
	aux_control_and_config_bytes aux_control_and_config_bytes_inst (.core_clk(core_clk),
		.nrst(nrst), .por_event(ev[0]), .bor_event(ev[1]), .wdt_event(ev[2]),
		.ext_reset_pin(ev[3]), .cfg_one_raw(cfg_one_raw), .keypad_pins(keypad_pins),
		.keypad_enable(keypad_enable), .brownout_detect(brownout_detect), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ptr_op(ptr_op),
		.data_pointer(data_pointer), .code_space_read(code_space_read),
		.external_space_move(external_space_move), .space_addr(space_addr), .cust_wr(cust_wr),
		.cust_widx(cust_widx), .cust_wdata(cust_wdata), .space_rdata(space_rdata),
		.space_hit(space_hit), .chip_reset(chip_reset), .restart_at_zero(restart_at_zero),
		.brownout_enable(brownout_enable), .brownout_irq(brownout_irq),
		.brownout_level_select(brownout_level_select),
		.low_power_memory_ctrl(low_power_memory_ctrl),
		.watchdog_reset_enable(watchdog_reset_enable),
		.shared_reset_pin_is_input(shared_reset_pin_is_input),
		.port_reset_level(port_reset_level), .machine_cycle_clks(machine_cycle_clks),
		.osc_mode(osc_mode), .osc_reserved(osc_reserved));
	core_model core_model_inst (.core_clk(core_clk), .sfr_rdata(sfr_rdata),
		.space_rdata(space_rdata), .space_hit(space_hit), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .ptr_op(ptr_op), .code_space_read(code_space_read),
		.external_space_move(external_space_move), .space_addr(space_addr));
	initial
	begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	// cuts a hang short well past the expected run length
	initial
	begin
		#80000;
		err_count++;
		end_of_test();
	end
	// ----------------------------------------
	// helper tasks
	// ----------------------------------------
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// pulse reset sources for one cycle, then count cycles with chip reset high
	task kick(input logic [3:0] m, output int cnt);
		cnt = 0;
		ev = m;
		@(negedge core_clk);
		ev = 4'h0;
		repeat (6)
		begin
			if (chip_reset === 1'b1) cnt++;
			@(negedge core_clk);
		end
	endtask
	function automatic osc_mode_e osc_exp(input logic [2:0] k);
		case (k)
			OSC_RC: osc_exp = OSC_SEL_RC;
			OSC_LOW: osc_exp = OSC_SEL_LOW;
			OSC_MID: osc_exp = OSC_SEL_MID;
			OSC_HIGH: osc_exp = OSC_SEL_HIGH;
			default: osc_exp = OSC_SEL_EXT;
		endcase
	endfunction
	task end_of_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		{nrst, brownout_detect, cust_wr, ev, cust_widx, cust_wdata, keypad_enable} = '0;
		cfg_one_raw = 8'hFF;
		keypad_pins = 8'hFF;
		repeat (16) @(negedge core_clk);
		nrst = 1'b1;
		repeat (2) @(negedge core_clk);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("aux reset", AUX_CTRL_RESET, d);
		chk("osc unprogrammed", OSC_SEL_EXT, osc_mode);
		chk("wdt unprogrammed", 1'b1, watchdog_reset_enable);
		for (i = 0; i < 6; i++)
		begin
			c = cfg_tab[i];
			cfg_one_raw = c;
			kick(4'h1, n);
			chk("wdt enable", c[CFG_WDOG], watchdog_reset_enable);
			chk("pin input", !c[CFG_PIN], shared_reset_pin_is_input);
			chk("port level", c[CFG_PORT], port_reset_level);
			chk("bo level", c[CFG_BROWN], brownout_level_select);
			chk("cycle clks", c[CFG_RATE] ? CYC_CLKS_FAST : CYC_CLKS_SLOW, machine_cycle_clks);
			chk("osc reserved", c[2] && c[1:0] != 2'h3, osc_reserved);
			if (!(c[2] && c[1:0] != 2'h3)) chk("osc mode", osc_exp(c[2:0]), osc_mode);
			kick(4'h4, n);
			chk("wdt reset", c[CFG_WDOG], n != 0);
			kick(4'h8, n);
			chk("pin reset", c[CFG_PIN], n != 0);
			cfg_one_raw = ~c;
			repeat (3) @(negedge core_clk);
			core_model_inst.space_read(1'b0, CFG_ONE_ADDR, d, h);
			chk("cfg read", c, d);
		end
		cfg_one_raw = CFG_UNPROGRAMMED;
		kick(4'h1, n);
		// keypad flag: disabled pin ignored, enabled pin sets and holds, write clears
		keypad_enable = 8'h04;
		keypad_pins = 8'hFE;
		repeat (3) @(negedge core_clk);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("key flag disabled pin", 1'b0, d[BIT_KEY_FLAG]);
		keypad_pins = 8'hFA;
		repeat (3) @(negedge core_clk);
		keypad_pins = 8'hFF;
		repeat (3) @(negedge core_clk);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("key flag held", 1'b1, d[BIT_KEY_FLAG]);
		core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h00);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("key flag cleared", 8'h00, d);
		// brownout controls and sticky low-power bit
		core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h55);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("bit2 zero", 8'h51, d);
		chk("bo enable", 1'b0, brownout_enable);
		kick(4'h2, n);
		chk("bo disabled reset", 0, n);
		core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h34);
		brownout_detect = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("bo irq", 1'b1, brownout_irq);
		kick(4'h2, n);
		chk("bo irq no reset", 0, n);
		core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h00);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("lpm sticky", 8'h10, d);
		chk("lpm pin", 1'b1, low_power_memory_ctrl);
		brownout_detect = 1'b0;
		kick(4'h2, n);
		chk("bo reset", 1, n);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("lpm cleared by bor", 8'h00, d);
		// dual pointers: increment of the register flips the select only
		core_model_inst.ptr_cmd(4'h4, 16'h1234);
		chk("ptr load", 16'h1234, data_pointer);
		core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h30);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		core_model_inst.sfr_write(AUX_CTRL_ADDR, d + 8'h01);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("increment select", 8'h31, d);
		chk("other ptr", PTR_RESET, data_pointer);
		core_model_inst.ptr_cmd(4'h8, 16'h0000);
		chk("ptr inc", PTR_STEP, data_pointer);
		core_model_inst.ptr_cmd(4'h2, 16'hABAB);
		core_model_inst.ptr_cmd(4'h1, 16'hCDCD);
		chk("ptr bytes", 16'hABCD, data_pointer);
		core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h30);
		chk("ptr kept", 16'h1234, data_pointer);
		// software reset fires once and keeps the low-power bit
		// count reset rising edges from the write strobe on; the pulse may span cycles
		n = 0;
		i = 0;
		h = 1'b0;
		fork
			core_model_inst.sfr_write(AUX_CTRL_ADDR, 8'h08);
			repeat (6)
			begin
				@(negedge core_clk);
				if (chip_reset === 1'b1 && h !== 1'b1) n++;
				if (restart_at_zero === 1'b1) i++;
				h = chip_reset;
			end
		join
		chk("soft reset once", 1, n);
		chk("restart at zero", 1'b1, i != 0);
		core_model_inst.sfr_read(AUX_CTRL_ADDR, d);
		chk("after soft reset", 8'h10, d);
		chk("ptr reinit", PTR_RESET, data_pointer);
		// signature, customer area and unmapped space
		cust_wr = 1'b1;
		cust_wdata = 8'h11;
		@(negedge core_clk);
		cust_widx = 5'h1F;
		cust_wdata = 8'hEE;
		@(negedge core_clk);
		cust_wr = 1'b0;
		@(negedge core_clk);
		for (i = 0; i < 3; i++)
		begin
			core_model_inst.space_read(1'b1, sig_a[i], d, h);
			chk("signature", sig_v[i], d);
			chk("sig hit", 1'b1, h);
		end
		core_model_inst.space_read(1'b1, CUST_BASE, d, h);
		chk("cust first", 8'h11, d);
		core_model_inst.space_read(1'b1, CUST_LAST, d, h);
		chk("cust last", 8'hEE, d);
		core_model_inst.space_read(1'b1, 16'hFC32, d, h);
		chk("unmapped hit", 1'b0, h);
		chk("unmapped data", 8'h00, d);
		end_of_test();
	end
endmodule
`default_nettype wire
